// *** design/pkc_pkg.sv ***
// Constants and types shared by the pad keeper control register block
package pkc_pkg;

   localparam int unsigned ADDR_W      = 16;
   localparam int unsigned DATA_W      = 32;
   localparam int unsigned KEEP_W      = 8;

   // Byte address of the pad keeper control register
   localparam logic [ADDR_W-1:0] KEEP_OFFSET = 16'h8800;
   localparam logic [KEEP_W-1:0] KEEP_RESET  = 8'h00;

   // Field positions inside the register
   localparam int unsigned BIT_EMUL_PULL    = 7;
   localparam int unsigned BIT_TEST_PULL    = 6;
   localparam int unsigned BIT_NMI_PULL     = 5;
   localparam int unsigned BIT_HOST_CTRL    = 4;
   localparam int unsigned BIT_HOST_DATA    = 3;
   localparam int unsigned BIT_MEM_CTRL     = 2;
   localparam int unsigned BIT_MEM_DATA     = 1;
   localparam int unsigned BIT_MEM_ADDR     = 0;

   // Pin group widths
   localparam int unsigned EMUL_PINS      = 2;
   localparam int unsigned TEST_PINS      = 4;
   localparam int unsigned HOST_CTRL_PINS = 10;
   localparam int unsigned HOST_DATA_PINS = 8;
   localparam int unsigned MEM_CTRL_PINS  = 16;
   localparam int unsigned MEM_DATA_PINS  = 32;
   localparam int unsigned MEM_ADDR_PINS  = 20;

   // Memory control pins 3 and 14 carry pullups, the rest bus holders
   localparam logic [MEM_CTRL_PINS-1:0] MEM_CTRL_PULL_MASK = 16'h4008;

   // Index of the pulldown pin within the test and host control groups
   localparam int unsigned TEST_TRST_IDX  = 3;
   localparam int unsigned HOST_CTRL_B_IDX = 1;

   typedef logic [KEEP_W-1:0] pkc_keep_t;

endpackage

// *** design/pkc_pad_if.sv ***
// Carrier between the register slave and the pad enable stage
`timescale 1ns/1ps
`default_nettype none
interface pkc_pad_if;
   pkc_pkg::pkc_keep_t                          keepBits;
   logic [pkc_pkg::EMUL_PINS-1:0]               emulEn;
   logic [pkc_pkg::TEST_PINS-1:0]               testEn;
   logic                                        nmiEn;
   logic [pkc_pkg::HOST_CTRL_PINS-1:0]          hostCtrlEn;
   logic [pkc_pkg::HOST_DATA_PINS-1:0]          hostDataEn;
   logic [pkc_pkg::MEM_CTRL_PINS-1:0]           memCtrlPullEn;
   logic [pkc_pkg::MEM_CTRL_PINS-1:0]           memCtrlHoldEn;
   logic [pkc_pkg::MEM_DATA_PINS-1:0]           memDataEn;
   logic [pkc_pkg::MEM_ADDR_PINS-1:0]           memAddrEn;

   modport regSide (
      output keepBits,
      input  emulEn, testEn, nmiEn, hostCtrlEn, hostDataEn,
      input  memCtrlPullEn, memCtrlHoldEn, memDataEn, memAddrEn
   );
   modport padSide (
      input  keepBits,
      output emulEn, testEn, nmiEn, hostCtrlEn, hostDataEn,
      output memCtrlPullEn, memCtrlHoldEn, memDataEn, memAddrEn
   );
endinterface
`default_nettype wire

// *** design/pkc_pad_enable.sv ***
// Turns stored disable bits into registered active-high pad enables
`timescale 1ns/1ps
`default_nettype none
module pkc_pad_enable (
   input  wire logic    sysClk,
   input  wire logic    rstn,
   pkc_pad_if.padSide   pad
);

   typedef struct packed {
      logic [pkc_pkg::EMUL_PINS-1:0]      emulEn;
      logic [pkc_pkg::TEST_PINS-1:0]      testEn;
      logic                               nmiEn;
      logic [pkc_pkg::HOST_CTRL_PINS-1:0] hostCtrlEn;
      logic [pkc_pkg::HOST_DATA_PINS-1:0] hostDataEn;
      logic [pkc_pkg::MEM_CTRL_PINS-1:0]  memCtrlPullEn;
      logic [pkc_pkg::MEM_CTRL_PINS-1:0]  memCtrlHoldEn;
      logic [pkc_pkg::MEM_DATA_PINS-1:0]  memDataEn;
      logic [pkc_pkg::MEM_ADDR_PINS-1:0]  memAddrEn;
   } pkc_pad_state_t;

   localparam pkc_pad_state_t PAD_RESET = '{
      emulEn:        '1,
      testEn:        '1,
      nmiEn:         1'b1,
      hostCtrlEn:    '1,
      hostDataEn:    '1,
      memCtrlPullEn: pkc_pkg::MEM_CTRL_PULL_MASK,
      memCtrlHoldEn: ~pkc_pkg::MEM_CTRL_PULL_MASK,
      memDataEn:     '1,
      memAddrEn:     '1
   };

   pkc_pad_state_t                     state_q;
   pkc_pad_state_t                     state_d;
   logic [pkc_pkg::MEM_CTRL_PINS-1:0]  memPull;
   logic [pkc_pkg::MEM_CTRL_PINS-1:0]  memHold;
   logic                               memCtrlOn;

   assign memCtrlOn = ~pad.keepBits[pkc_pkg::BIT_MEM_CTRL];

   // Pullup or holder per control pin, never both
   for (genvar i = 0; i < pkc_pkg::MEM_CTRL_PINS; i++) begin : gMemCtrl
      assign memPull[i] = memCtrlOn & pkc_pkg::MEM_CTRL_PULL_MASK[i];
      assign memHold[i] = memCtrlOn & ~pkc_pkg::MEM_CTRL_PULL_MASK[i];
   end

   // No pin-mux select enters here, so a dual-function pin keeps its setting
   always_comb begin
      state_d               = state_q;
      state_d.emulEn        = {pkc_pkg::EMUL_PINS{~pad.keepBits[pkc_pkg::BIT_EMUL_PULL]}};
      state_d.testEn        = {pkc_pkg::TEST_PINS{~pad.keepBits[pkc_pkg::BIT_TEST_PULL]}};
      state_d.nmiEn         = ~pad.keepBits[pkc_pkg::BIT_NMI_PULL];
      state_d.hostCtrlEn    = {pkc_pkg::HOST_CTRL_PINS{~pad.keepBits[pkc_pkg::BIT_HOST_CTRL]}};
      state_d.hostDataEn    = {pkc_pkg::HOST_DATA_PINS{~pad.keepBits[pkc_pkg::BIT_HOST_DATA]}};
      state_d.memCtrlPullEn = memPull;
      state_d.memCtrlHoldEn = memHold;
      state_d.memDataEn     = {pkc_pkg::MEM_DATA_PINS{~pad.keepBits[pkc_pkg::BIT_MEM_DATA]}};
      state_d.memAddrEn     = {pkc_pkg::MEM_ADDR_PINS{~pad.keepBits[pkc_pkg::BIT_MEM_ADDR]}};
   end

   // One cycle behind the stored bits
   always_ff @(posedge sysClk or negedge rstn) begin
      if (!rstn) begin
         state_q <= PAD_RESET;
      end else begin
         state_q <= state_d;
      end
   end

   assign pad.emulEn        = state_q.emulEn;
   assign pad.testEn        = state_q.testEn;
   assign pad.nmiEn         = state_q.nmiEn;
   assign pad.hostCtrlEn    = state_q.hostCtrlEn;
   assign pad.hostDataEn    = state_q.hostDataEn;
   assign pad.memCtrlPullEn = state_q.memCtrlPullEn;
   assign pad.memCtrlHoldEn = state_q.memCtrlHoldEn;
   assign pad.memDataEn     = state_q.memDataEn;
   assign pad.memAddrEn     = state_q.memAddrEn;

endmodule
`default_nettype wire

// *** design/pkc_pad_keeper_control.sv ***
// APB slave holding the pad keeper control register and its pad enables
//
// Summary of operation
// - A 16-bit register at 0x8800 whose bits 15-8 read zero and whose bits 7-0 reset to zero.
// - Bit 7 set turns off the pullups on both emulation pins, clear leaves them on.
// - Bit 6 set turns off the test port pullups and the reset-pin pulldown, not the emulation pins.
// - Bit 5 set turns off the pullup on the interrupt and watchdog output pin.
// - Bit 4 set turns off the host control pin pulls, a pulldown on the second pin and pullups elsewhere.
// - Bit 3 set turns off the bus holders on the eight host data pins.
// - Bit 2 set turns off the memory control pin features, pullups on pins 3 and 14 and holders on the rest.
// - Bit 1 set turns off the bus holders on the 32 memory data pins.
// - Bit 0 set turns off the bus holders on memory address pins 21 down to 2.
// - Every setting applies whatever function a shared pin is performing at the time.
`timescale 1ns/1ps
`default_nettype none
module pkc_pad_keeper_control (
   input  wire logic                                 sys_clk,
   input  wire logic                                 rstn,
   input  wire logic                                 psel,
   input  wire logic                                 penable,
   input  wire logic                                 pwrite,
   input  wire logic [pkc_pkg::ADDR_W-1:0]           paddr,
   input  wire logic [pkc_pkg::DATA_W-1:0]           pwdata,
   output var  logic [pkc_pkg::DATA_W-1:0]           prdata,
   output var  logic                                 pready,
   output var  logic                                 pslverr,
   output var  logic                                 emulPinZeroPullEn,
   output var  logic                                 emulPinOnePullEn,
   output var  logic                                 tckPullEn,
   output var  logic                                 tdiPullEn,
   output var  logic                                 tmsPullEn,
   output var  logic                                 trstPullDownEn,
   output var  logic                                 nmiWatchdogPinPullEn,
   output var  logic                                 hostControlPinAPullEn,
   output var  logic                                 hostControlPinBPullDownEn,
   output var  logic [pkc_pkg::HOST_CTRL_PINS-3:0]   hostCtrlOtherPullEn,
   output var  logic [pkc_pkg::HOST_DATA_PINS-1:0]   hostDataHoldEn,
   output var  logic [pkc_pkg::MEM_CTRL_PINS-1:0]    memCtrlPullEn,
   output var  logic [pkc_pkg::MEM_CTRL_PINS-1:0]    memCtrlHoldEn,
   output var  logic [pkc_pkg::MEM_DATA_PINS-1:0]    memDataHoldEn,
   output var  logic [pkc_pkg::MEM_ADDR_PINS-1:0]    memAddrHoldEn
);

   typedef struct packed {
      pkc_pkg::pkc_keep_t              keep;
      logic                            ready;
      logic                            slvErr;
      logic [pkc_pkg::DATA_W-1:0]      rdata;
   } pkc_bus_state_t;

   localparam pkc_bus_state_t BUS_RESET = '{
      keep:   pkc_pkg::KEEP_RESET,
      ready:  1'b0,
      slvErr: 1'b0,
      rdata:  '0
   };

   pkc_bus_state_t   bus_q;
   pkc_bus_state_t   bus_d;
   logic             setupPhase;
   logic             accessDone;
   logic             addrHit;

   pkc_pad_if padBus ();

   assign setupPhase = psel & ~penable;
   assign accessDone = psel & penable & bus_q.ready;
   assign addrHit    = (paddr == pkc_pkg::KEEP_OFFSET);

   // Answer is prepared in the setup cycle so every access ends without wait states
   always_comb begin
      bus_d = bus_q;
      if (setupPhase) begin
         bus_d.ready  = 1'b1;
         bus_d.slvErr = ~addrHit;
         // Upper halfword and reserved bits 15-8 read zero
         bus_d.rdata  = addrHit ? {{(pkc_pkg::DATA_W-pkc_pkg::KEEP_W){1'b0}}, bus_q.keep} : '0;
      end else if (accessDone) begin
         bus_d.ready  = 1'b0;
         bus_d.slvErr = 1'b0;
         bus_d.rdata  = '0;
         // Only the low byte is storage; reserved bits ignore writes
         if (pwrite && addrHit) begin
            bus_d.keep = pwdata[pkc_pkg::KEEP_W-1:0];
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         bus_q <= BUS_RESET;
      end else begin
         bus_q <= bus_d;
      end
   end

   assign padBus.keepBits = bus_q.keep;

   pkc_pad_enable uPadEnable (
      .sysClk (sys_clk),
      .rstn   (rstn),
      .pad    (padBus)
   );

   assign prdata  = bus_q.rdata;
   assign pready  = bus_q.ready;
   assign pslverr = bus_q.slvErr;

   // Pad enables come straight from the enable stage flops
   assign emulPinZeroPullEn         = padBus.emulEn[0];
   assign emulPinOnePullEn          = padBus.emulEn[1];
   assign tckPullEn                 = padBus.testEn[0];
   assign tdiPullEn                 = padBus.testEn[1];
   assign tmsPullEn                 = padBus.testEn[2];
   assign trstPullDownEn            = padBus.testEn[pkc_pkg::TEST_TRST_IDX];
   assign nmiWatchdogPinPullEn      = padBus.nmiEn;
   assign hostControlPinAPullEn     = padBus.hostCtrlEn[0];
   assign hostControlPinBPullDownEn = padBus.hostCtrlEn[pkc_pkg::HOST_CTRL_B_IDX];
   // Order: sel_a, sel_b, chip select, read/write, strobe_a, strobe_b, ready, interrupt
   assign hostCtrlOtherPullEn       = padBus.hostCtrlEn[pkc_pkg::HOST_CTRL_PINS-1:2];
   assign hostDataHoldEn            = padBus.hostDataEn;
   assign memCtrlPullEn             = padBus.memCtrlPullEn;
   assign memCtrlHoldEn             = padBus.memCtrlHoldEn;
   assign memDataHoldEn             = padBus.memDataEn;
   // Bit 0 is address line 2
   assign memAddrHoldEn             = padBus.memAddrEn;

endmodule
`default_nettype wire

// *** dv/pkc_keeper_asserts.sv ***
// Port-level checks for the pad keeper control register
`timescale 1ns/1ps
`default_nettype none
module pkc_keeper_asserts (
   input wire logic        sys_clk,
   input wire logic        rstn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [15:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        emulPinZeroPullEn,
   input wire logic        emulPinOnePullEn,
   input wire logic        tckPullEn,
   input wire logic        tdiPullEn,
   input wire logic        tmsPullEn,
   input wire logic        trstPullDownEn,
   input wire logic        nmiWatchdogPinPullEn,
   input wire logic        hostControlPinAPullEn,
   input wire logic        hostControlPinBPullDownEn,
   input wire logic [7:0]  hostCtrlOtherPullEn,
   input wire logic [7:0]  hostDataHoldEn,
   input wire logic [15:0] memCtrlPullEn,
   input wire logic [15:0] memCtrlHoldEn,
   input wire logic [31:0] memDataHoldEn,
   input wire logic [19:0] memAddrHoldEn
);
   logic       wr;
   logic [7:0] inv;
   assign wr = psel && penable && pready && pwrite && paddr == pkc_pkg::KEEP_OFFSET;
   // One pin per group suffices; the group checks tie the rest to it
   assign inv = ~{emulPinZeroPullEn, tckPullEn, nmiWatchdogPinPullEn, hostControlPinAPullEn,
                  hostDataHoldEn[0], memCtrlHoldEn[0], memDataHoldEn[0], memAddrHoldEn[0]};
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rstn);
   a_emul_pull: assert property (wr |-> ##2 {emulPinZeroPullEn, emulPinOnePullEn} == {2{!$past(pwdata[7], 2)}})
      else $error("emulation pull enables wrong");
   a_test_pull: assert property (wr |-> ##2 {tckPullEn, tdiPullEn, tmsPullEn, trstPullDownEn} == {4{!$past(pwdata[6], 2)}})
      else $error("test port pull enables wrong");
   a_nmi_pull: assert property (wr |-> ##2 nmiWatchdogPinPullEn != $past(pwdata[5], 2))
      else $error("interrupt pin pull enable wrong");
   a_host_ctrl: assert property (wr |-> ##2 {hostControlPinAPullEn, hostControlPinBPullDownEn, hostCtrlOtherPullEn} == {10{!$past(pwdata[4], 2)}})
      else $error("host control pull enables wrong");
   a_host_data: assert property (wr |-> ##2 hostDataHoldEn == {8{!$past(pwdata[3], 2)}})
      else $error("host data holders wrong");
   a_mem_ctrl: assert property (wr |-> ##2 {memCtrlPullEn, memCtrlHoldEn} == ($past(pwdata[2], 2) ? 32'h0 : 32'h4008bff7))
      else $error("memory control enables wrong");
   a_mem_data: assert property (wr |-> ##2 memDataHoldEn == {32{!$past(pwdata[1], 2)}})
      else $error("memory data holders wrong");
   a_mem_addr: assert property (wr |-> ##2 memAddrHoldEn == {20{!$past(pwdata[0], 2)}})
      else $error("memory address holders wrong");
   a_pad_delay: assert property (wr |=> $stable(memDataHoldEn) && $stable(memAddrHoldEn))
      else $error("pad enables moved too early");
   a_read_value: assert property (psel && penable && !pwrite && paddr == pkc_pkg::KEEP_OFFSET |-> pready && prdata == {24'h0, inv})
      else $error("read data differs from pad state");
   a_unmapped_err: assert property (psel && penable && paddr != pkc_pkg::KEEP_OFFSET |-> pready && pslverr && prdata == 32'h0)
      else $error("unmapped access not refused");
endmodule
bind pkc_pad_keeper_control pkc_keeper_asserts i_chk (
   .sys_clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
   .emulPinZeroPullEn, .emulPinOnePullEn, .tckPullEn, .tdiPullEn, .tmsPullEn, .trstPullDownEn,
   .nmiWatchdogPinPullEn, .hostControlPinAPullEn, .hostControlPinBPullDownEn, .hostCtrlOtherPullEn,
   .hostDataHoldEn, .memCtrlPullEn, .memCtrlHoldEn, .memDataHoldEn, .memAddrHoldEn
);
`default_nettype wire

// *** dv/tb.sv ***
// Self-checking bench for the pad keeper control register
`timescale 1ns/1ps
`default_nettype none
module tb;
   localparam logic [15:0] OFF = pkc_pkg::KEEP_OFFSET;
   logic         sys_clk, rstn, psel, penable, pwrite, pready, pslverr, er;
   logic [15:0]  paddr, memCtrlPullEn, memCtrlHoldEn;
   logic [31:0]  pwdata, prdata, rd, memDataHoldEn;
   logic         emulPinZeroPullEn, emulPinOnePullEn, tckPullEn, tdiPullEn, tmsPullEn, trstPullDownEn;
   logic         nmiWatchdogPinPullEn, hostControlPinAPullEn, hostControlPinBPullDownEn;
   logic [7:0]   hostCtrlOtherPullEn, hostDataHoldEn;
   logic [19:0]  memAddrHoldEn;
   logic [108:0] pads;
   int           error_cnt = 0;
   int           cmp_count = 0;
   assign pads = {emulPinZeroPullEn, emulPinOnePullEn, tckPullEn, tdiPullEn, tmsPullEn, trstPullDownEn,
                  nmiWatchdogPinPullEn, hostControlPinAPullEn, hostControlPinBPullDownEn, hostCtrlOtherPullEn,
                  hostDataHoldEn, memCtrlPullEn, memCtrlHoldEn, memDataHoldEn, memAddrHoldEn};
   pkc_pad_keeper_control i_pkc_pad_keeper_control (
      .sys_clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .emulPinZeroPullEn, .emulPinOnePullEn, .tckPullEn, .tdiPullEn, .tmsPullEn, .trstPullDownEn,
      .nmiWatchdogPinPullEn, .hostControlPinAPullEn, .hostControlPinBPullDownEn, .hostCtrlOtherPullEn,
      .hostDataHoldEn, .memCtrlPullEn, .memCtrlHoldEn, .memDataHoldEn, .memAddrHoldEn
   );
   initial begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end
   function automatic logic [108:0] exp_pads(input logic [7:0] k);
      return {{2{~k[7]}}, {4{~k[6]}}, ~k[5], {10{~k[4]}}, {8{~k[3]}}, (k[2] ? 32'h0 : 32'h4008bff7),
              {32{~k[1]}}, {20{~k[0]}}};
   endfunction
   task automatic chkp(input logic [108:0] g, input logic [108:0] e);
      cmp_count++;
      if (g !== e) begin
         error_cnt++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic chk32(input logic [31:0] g, input logic [31:0] e);
      cmp_count++;
      if (g !== e) begin
         error_cnt++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   // Zero-wait slave, but the master still waits on pready; only the watchdog ends a hang
   task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      do begin
         @(posedge sys_clk);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic t_reset();
      apb(1'b0, OFF, 32'h0);
      chk32(rd, 32'h0);
      chk32({31'h0, er}, 32'h0);
      chkp(pads, exp_pads(8'h00));
      $display("reset values done");
   endtask
   task automatic t_bits();
      logic [7:0] k;
      for (int b = 0; b < 10; b++) begin
         k = (b == 8) ? 8'hff : (b == 9) ? 8'h00 : 8'h01 << b;
         // Upper write bits are junk on purpose; they must not stick
         apb(1'b1, OFF, {24'hffffff, k});
         repeat (2) @(posedge sys_clk);
         chkp(pads, exp_pads(k));
         apb(1'b0, OFF, 32'h0);
         chk32(rd, {24'h0, k});
      end
      $display("single bits done");
   endtask
   task automatic t_unmapped();
      apb(1'b1, OFF, 32'h0000005a);
      apb(1'b1, 16'h8804, 32'h000000ff);
      chk32({31'h0, er}, 32'h1);
      apb(1'b0, 16'h8804, 32'h0);
      chk32(rd, 32'h0);
      chk32({31'h0, er}, 32'h1);
      apb(1'b0, OFF, 32'h0);
      chk32(rd, 32'h0000005a);
      chkp(pads, exp_pads(8'h5a));
      $display("unmapped access done");
   endtask
   task automatic t_midreset();
      apb(1'b1, OFF, 32'h000000a5);
      @(posedge sys_clk);
      rstn <= 1'b0;
      @(posedge sys_clk);
      chkp(pads, exp_pads(8'h00));
      rstn <= 1'b1;
      apb(1'b0, OFF, 32'h0);
      chk32(rd, 32'h0);
      $display("mid-run reset done");
   endtask
   task automatic report_and_stop();
      $display("compares %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   initial begin
      rstn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 16'h0;
      pwdata = 32'h0;
      repeat (3) @(posedge sys_clk);
      rstn <= 1'b1;
      t_reset();
      t_bits();
      t_unmapped();
      t_midreset();
      report_and_stop();
   end
   initial begin
      repeat (4000) @(posedge sys_clk);
      error_cnt++;
      report_and_stop();
   end
endmodule
`default_nettype wire
